// ===== include/sensor_cfg_defines.vh
// Offsets, field positions and codes of the output configuration bank
`ifndef SENSOR_CFG_DEFINES_VH
`define SENSOR_CFG_DEFINES_VH
`define ADDR_W 12
`define OFS_LOCK_MASK 12'h09a
`define OFS_PAD_NUM 12'h09c
`define OFS_PAD_LET 12'h09e
`define OFS_ANGLE 12'h0a0
`define OFS_MODE 12'h0a2
`define RST_WORD 16'h0000
`define BIT_OV_OFF 15
`define BIT_SPIKE 14
`define BIT_OD_3C 11
`define BIT_OD_2B 9
`define BIT_OD_1A 7
`define SLP_HI 15
`define SLP_LO 14
`define SLP_2US 2'h0
`define SLP_4US 2'h1
`define SLP_6US 2'h2
`define SLP_TRI 2'h3
`define ANG_HI 15
`define ANG_LO 2
`define BIT_DIR 1
`define BIT_RSVD 0
`endif

// ===== logic/cfg_word.v
// One 16-bit configuration word with load and software write
`timescale 1ns/1ps
`include "sensor_cfg_defines.vh"
module cfg_word (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Write sources
  input wire load,
  input wire [15:0] load_data,
  input wire wr,
  input wire [15:0] wr_data,
  // Stored value
  output reg [15:0] q_r
);
  // Startup load wins over a software write in the same cycle
  always @(posedge clk) begin
    if (reset) begin
      q_r <= `RST_WORD;
    end else if (load) begin
      q_r <= load_data;
    end else if (wr) begin
      q_r <= wr_data;
    end
  end
endmodule // cfg_word

// ===== logic/sensor_output_config_bank.v
// Output configuration register bank: lock mask, pad setup, angle offset
//
// What this block does
// - Effective interface mode equals mode word ANDed bitwise with lock mask.
// - Mode word reads back as written; locked bits are only blocked in effect.
// - Pad word one bit 15: zero keeps overvoltage shutoff, one disables it.
// - Pad word one bit 14 set enables the input spike filter.
// - Pad word one bits 11, 9, 7 pick open-drain for pins 3, 2, 1.
// - Pad word two bits 11 and 7 pick open-drain for pins C and A.
// - Pad word two bit 9 picks open-drain with edge control for pin B.
// - Pad word two bits 15:14 set pin B slope 2, 4, 6 us or tristate.
// - Angle word bits 15:2 hold a signed 14-bit zero offset.
// - Angle word bit 1 selects positive direction: zero ccw, one cw.
`timescale 1ns/1ps
`include "sensor_cfg_defines.vh"
module sensor_output_config_bank (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Word access port
  input wire [`ADDR_W-1:0] addr,
  input wire wr_en,
  input wire rd_en,
  input wire [15:0] wr_data,
  output reg [15:0] rd_data_r,
  output reg rd_valid_r,
  output reg addr_err_r,
  // Startup load from nonvolatile memory
  input wire nv_load,
  input wire [15:0] nv_lock_mask,
  input wire [15:0] nv_pad_num,
  input wire [15:0] nv_pad_let,
  input wire [15:0] nv_angle,
  input wire [15:0] nv_mode,
  // Configuration status
  output reg cfg_valid_r,
  // Effective settings
  output reg [15:0] interface_mode_eff_r,
  output reg overvoltage_protect_enable_r,
  output reg spike_filter_enable_r,
  output reg pin1_opendrain_select_r,
  output reg pin2_opendrain_select_r,
  output reg pin3_opendrain_select_r,
  output reg pin_a_opendrain_select_r,
  output reg pin_b_opendrain_select_r,
  output reg pin_b_edge_control_r,
  output reg pin_c_opendrain_select_r,
  output reg [1:0] pin_b_slope_select_r,
  output reg pin_b_tristate_r,
  output reg signed [13:0] angle_zero_offset_r,
  output reg rotation_direction_r
);
  wire [15:0] lock_mask_word;
  wire [15:0] pad_num_word;
  wire [15:0] pad_let_word;
  wire [15:0] angle_word;
  wire [15:0] interface_mode_word;
  wire sel_lock = (addr == `OFS_LOCK_MASK);
  wire sel_num = (addr == `OFS_PAD_NUM);
  wire sel_let = (addr == `OFS_PAD_LET);
  wire sel_ang = (addr == `OFS_ANGLE);
  wire sel_mode = (addr == `OFS_MODE);
  wire hit = sel_lock | sel_num | sel_let | sel_ang | sel_mode;
  // Bit 0 of the angle word is kept from the stored value on writes,
  // so a careless full-word write cannot disturb it
  wire [15:0] ang_wr = {wr_data[15:1], angle_word[`BIT_RSVD]};

  ////////////////////////////////////////////////////////////////////////
  // Storage words; test bits stored as written, no effect here
  // Lock mask, one gate bit per mode bit
  cfg_word u_lock (
    .clk(clk),
    .reset(reset),
    .load(nv_load),
    .load_data(nv_lock_mask),
    .wr(wr_en & sel_lock),
    .wr_data(wr_data),
    .q_r(lock_mask_word)
  );
  // Pad setup of the numbered pins
  cfg_word u_num (
    .clk(clk),
    .reset(reset),
    .load(nv_load),
    .load_data(nv_pad_num),
    .wr(wr_en & sel_num),
    .wr_data(wr_data),
    .q_r(pad_num_word)
  );
  // Pad setup of the lettered pins
  cfg_word u_let (
    .clk(clk),
    .reset(reset),
    .load(nv_load),
    .load_data(nv_pad_let),
    .wr(wr_en & sel_let),
    .wr_data(wr_data),
    .q_r(pad_let_word)
  );
  // Angle word; bit 0 is fed back from itself on writes
  cfg_word u_ang (
    .clk(clk),
    .reset(reset),
    .load(nv_load),
    .load_data(nv_angle),
    .wr(wr_en & sel_ang),
    .wr_data(ang_wr),
    .q_r(angle_word)
  );
  // Interface mode word exactly as software wrote it
  cfg_word u_mode (
    .clk(clk),
    .reset(reset),
    .load(nv_load),
    .load_data(nv_mode),
    .wr(wr_en & sel_mode),
    .wr_data(wr_data),
    .q_r(interface_mode_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // Readback: raw stored words, mode word unmasked
  always @(posedge clk) begin
    if (reset) begin
      rd_data_r <= 16'h0000;
      rd_valid_r <= 1'b0;
      addr_err_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_en;
      addr_err_r <= (rd_en | wr_en) & ~hit;
      if (rd_en) begin
        if (sel_lock) begin
          rd_data_r <= lock_mask_word;
        end else if (sel_num) begin
          rd_data_r <= pad_num_word;
        end else if (sel_let) begin
          rd_data_r <= pad_let_word;
        end else if (sel_ang) begin
          rd_data_r <= angle_word;
        end else if (sel_mode) begin
          rd_data_r <= interface_mode_word;
        end else begin
          rd_data_r <= 16'h0000; // Unmapped reads as zero
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration counts as valid after the first startup load
  always @(posedge clk) begin
    if (reset) begin
      cfg_valid_r <= 1'b0;
    end else if (nv_load) begin
      cfg_valid_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Effective settings; held at safe defaults until loaded, so pads do
  // not act on reset values that never came from nonvolatile memory
  wire hold_defaults = reset | ~cfg_valid_r;

  // Interface mode: locked bits are cut here only, readback stays raw
  always @(posedge clk) begin
    if (hold_defaults) begin
      interface_mode_eff_r <= 16'h0000;
    end else begin
      interface_mode_eff_r <= interface_mode_word & lock_mask_word;
    end
  end

  // Numbered pins; overvoltage shutoff stays armed by default
  always @(posedge clk) begin
    if (hold_defaults) begin
      overvoltage_protect_enable_r <= 1'b1;
      spike_filter_enable_r <= 1'b0;
      pin1_opendrain_select_r <= 1'b0;
      pin2_opendrain_select_r <= 1'b0;
      pin3_opendrain_select_r <= 1'b0;
    end else begin
      overvoltage_protect_enable_r <= ~pad_num_word[`BIT_OV_OFF];
      spike_filter_enable_r <= pad_num_word[`BIT_SPIKE];
      pin3_opendrain_select_r <= pad_num_word[`BIT_OD_3C];
      pin2_opendrain_select_r <= pad_num_word[`BIT_OD_2B];
      pin1_opendrain_select_r <= pad_num_word[`BIT_OD_1A];
    end
  end

  // Lettered pins; pin B open-drain always comes with edge control
  always @(posedge clk) begin
    if (hold_defaults) begin
      pin_a_opendrain_select_r <= 1'b0;
      pin_b_opendrain_select_r <= 1'b0;
      pin_b_edge_control_r <= 1'b0;
      pin_c_opendrain_select_r <= 1'b0;
      pin_b_slope_select_r <= `SLP_2US;
      pin_b_tristate_r <= 1'b0;
    end else begin
      pin_c_opendrain_select_r <= pad_let_word[`BIT_OD_3C];
      pin_a_opendrain_select_r <= pad_let_word[`BIT_OD_1A];
      pin_b_opendrain_select_r <= pad_let_word[`BIT_OD_2B];
      pin_b_edge_control_r <= pad_let_word[`BIT_OD_2B];
      pin_b_slope_select_r <= pad_let_word[`SLP_HI:`SLP_LO];
      pin_b_tristate_r <= (pad_let_word[`SLP_HI:`SLP_LO] == `SLP_TRI);
    end
  end

  // Angle offset and direction; zero offset is the neutral default
  always @(posedge clk) begin
    if (hold_defaults) begin
      angle_zero_offset_r <= 14'h0000;
      rotation_direction_r <= 1'b0;
    end else begin
      angle_zero_offset_r <= angle_word[`ANG_HI:`ANG_LO];
      rotation_direction_r <= angle_word[`BIT_DIR];
    end
  end
endmodule // sensor_output_config_bank

// ===== verification/sensor_cfg_props.sv
// Assertions on the ports of the output configuration bank
`timescale 1ns/1ps
module sensor_cfg_props (
  // Clock, reset and startup load
  input wire clk, reset, nv_load, cfg_valid_r,
  input wire [15:0] nv_lock_mask, nv_pad_num, nv_pad_let, nv_angle, nv_mode,
  // Effective settings
  input wire [15:0] interface_mode_eff_r,
  input wire overvoltage_protect_enable_r, spike_filter_enable_r, pin1_opendrain_select_r,
  input wire pin2_opendrain_select_r, pin3_opendrain_select_r, pin_a_opendrain_select_r,
  input wire pin_b_opendrain_select_r, pin_b_edge_control_r, pin_c_opendrain_select_r,
  input wire [1:0] pin_b_slope_select_r,
  input wire pin_b_tristate_r, rotation_direction_r,
  input wire signed [13:0] angle_zero_offset_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Load edge, word stored, then settings follow; a later write cannot overtake it
  sequence s_load;
    nv_load ##2 1'h1;
  endsequence
  a_mode_lock_and: assert property (s_load |-> interface_mode_eff_r ==
    ($past(nv_mode, 2) & $past(nv_lock_mask, 2))) else $error("mode gating wrong");
  a_ov_spike_bits: assert property (s_load |-> {overvoltage_protect_enable_r,
    spike_filter_enable_r} == {!$past(nv_pad_num[15], 2), $past(nv_pad_num[14], 2)})
    else $error("overvoltage or spike setting wrong");
  a_num_pins_od: assert property (s_load |-> {pin3_opendrain_select_r,
    pin2_opendrain_select_r, pin1_opendrain_select_r} == {$past(nv_pad_num[11], 2),
    $past(nv_pad_num[9], 2), $past(nv_pad_num[7], 2)}) else $error("numbered pin drive wrong");
  a_let_pins_od: assert property (s_load |-> {pin_c_opendrain_select_r,
    pin_a_opendrain_select_r} == {$past(nv_pad_let[11], 2), $past(nv_pad_let[7], 2)})
    else $error("lettered pin drive wrong");
  a_pin_b_edge: assert property (s_load |-> {pin_b_opendrain_select_r,
    pin_b_edge_control_r} == {2{$past(nv_pad_let[9], 2)}}) else $error("pin b drive wrong");
  a_pin_b_slope: assert property (s_load |->
    pin_b_slope_select_r == $past(nv_pad_let[15:14], 2)) else $error("slope wrong");
  a_tristate_code: assert property (pin_b_tristate_r == (pin_b_slope_select_r == 2'h3))
    else $error("tristate mismatch");
  a_angle_fields: assert property (s_load |-> {angle_zero_offset_r,
    rotation_direction_r} == $past(nv_angle[15:1], 2)) else $error("angle fields wrong");
  // Before any load the outputs must sit at safe values
  a_safe_defaults: assert property (!cfg_valid_r |-> overvoltage_protect_enable_r
    && !spike_filter_enable_r && interface_mode_eff_r == 16'h0000) else $error("not defaults");
endmodule // sensor_cfg_props
bind sensor_output_config_bank sensor_cfg_props u_sensor_cfg_props (.*);

// ===== verification/testbench.sv
// Self-checking bench for the output configuration bank
`timescale 1ns/1ps
module testbench;
  reg clk = 0, reset = 1, wr_en = 0, rd_en = 0, nv_load = 0;
  reg [11:0] addr = 0;
  reg [15:0] wr_data = 0, nv_lock_mask = 0, nv_pad_num = 0, nv_pad_let = 0, nv_angle = 0;
  reg [15:0] nv_mode = 0, got;
  reg [1:0] flags;
  wire [15:0] rd_data_r, interface_mode_eff_r;
  wire rd_valid_r, addr_err_r, cfg_valid_r, overvoltage_protect_enable_r, spike_filter_enable_r;
  wire pin1_opendrain_select_r, pin2_opendrain_select_r, pin3_opendrain_select_r;
  wire pin_a_opendrain_select_r, pin_b_opendrain_select_r, pin_b_edge_control_r;
  wire pin_c_opendrain_select_r, pin_b_tristate_r, rotation_direction_r;
  wire [1:0] pin_b_slope_select_r;
  wire signed [13:0] angle_zero_offset_r;
  integer mismatches = 0, n_compared = 0, cyc = 0, i;
  always #10 clk = ~clk;
  sensor_output_config_bank u_sensor_output_config_bank (.*);
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input [17:0] seen, input [17:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [11:0] a, input [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask
  // Data and flags are taken just after the answering edge has landed
  task rd(input [11:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1 got = rd_data_r;
    flags = {addr_err_r, rd_valid_r};
  endtask
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_load;
    chk("defaults", {cfg_valid_r, overvoltage_protect_enable_r}, 16'h0001);
    @(posedge clk);
    nv_lock_mask <= 16'h00f0;
    nv_mode <= 16'h0f00;
    nv_pad_num <= 16'h8280; // Test bits left clear
    nv_pad_let <= 16'h4a80;
    nv_angle <= 16'h8003;
    nv_load <= 1'h1;
    @(posedge clk);
    nv_load <= 1'h0;
    settle;
    chk("valid", cfg_valid_r, 16'h0001);
    chk("eff_mode", interface_mode_eff_r, 16'h0000);
    chk("num_pads", {overvoltage_protect_enable_r, spike_filter_enable_r, pin3_opendrain_select_r,
      pin2_opendrain_select_r, pin1_opendrain_select_r}, 16'h0003);
    chk("let_pads", {pin_c_opendrain_select_r, pin_b_opendrain_select_r, pin_b_edge_control_r,
      pin_a_opendrain_select_r, pin_b_slope_select_r, pin_b_tristate_r},
      16'h007a);
    chk("angle", {angle_zero_offset_r, rotation_direction_r}, 16'h4001);
  endtask
  task t_lock;
    wr(12'h0a2, 16'hffff);
    rd(12'h0a2);
    chk("mode_read", {flags, got}, 18'h1ffff);
    settle;
    chk("eff_mode", interface_mode_eff_r, 16'h00f0);
  endtask
  // Numbered pins flipped against the load, then every slope code
  task t_slope;
    wr(12'h09c, 16'h4800); // Test bits left clear
    settle;
    chk("num_pads", {overvoltage_protect_enable_r, spike_filter_enable_r, pin3_opendrain_select_r,
      pin2_opendrain_select_r, pin1_opendrain_select_r}, 16'h001c);
    for (i = 0; i < 4; i = i + 1) begin
      wr(12'h09e, {i[1:0], 14'h0000});
      settle;
      chk("slope", {pin_c_opendrain_select_r, pin_b_opendrain_select_r, pin_b_edge_control_r,
        pin_a_opendrain_select_r, pin_b_slope_select_r, pin_b_tristate_r},
        {4'h0, i[1:0], i == 3});
    end
  endtask
  // A careless write cannot move bit 0; then a proper read-modify-write
  task t_angle;
    wr(12'h0a0, 16'h7ffc);
    rd(12'h0a0);
    chk("angle_read", got, 16'h7ffd);
    settle;
    chk("angle", {angle_zero_offset_r, rotation_direction_r}, 16'h3ffe);
    wr(12'h0a0, {14'h0001, 1'h1, got[0]}); // Bit 0 written back as read
    rd(12'h0a0);
    chk("angle_rmw", got, 16'h0007);
    settle;
    chk("angle_small", {angle_zero_offset_r, rotation_direction_r}, 16'h0003);
    rd(12'h0b0);
    chk("unmapped", {flags, got}, 18'h30000);
  endtask
  // Mid-run reset clears stored words and drops back to safe defaults
  task t_reset;
    @(posedge clk);
    reset <= 1'h1;
    @(posedge clk);
    reset <= 1'h0;
    #1;
    chk("reset_defaults", {cfg_valid_r, overvoltage_protect_enable_r, interface_mode_eff_r},
      18'h10000);
    rd(12'h0a2);
    chk("reset_read", {flags, got}, 18'h10000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard, far above the fewer than a hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    #1;
    t_load;
    t_lock;
    t_slope;
    t_angle;
    t_reset;
    wrap_up;
  end
endmodule // testbench
